// >>> dv/psb_ctrl_model.sv
`timescale 1ns/100ps
module psb_ctrl_model (
  input wire logic clk_in,
  input wire logic [15:0] rd_dq_in,
  input wire logic [1:0] rd_oe_in,
  input wire logic wait_in,
  input wire logic wait_oe_in,
  output psb_pkg::psb_ctrl_type ctrl_out,
  output logic [19:0] addr_out,
  output logic [15:0] dq_out,
  output logic mem_clk_out
);
  // idle: deselected, address valid low
  localparam logic [6:0] IDLE = 7'h7C;
  initial begin
    ctrl_out = IDLE;
    addr_out = 20'h00000;
    dq_out = 16'h0000;
    mem_clk_out = 1'h0;
  end
  // strobes held three edges, far below max_select_low_time
  task automatic drive(input psb_pkg::psb_ctrl_type c, input logic [19:0] a, input logic [15:0] d);
    @(posedge clk_in);
    ctrl_out <= c;
    addr_out <= a;
    dq_out <= d;
    repeat (3) @(posedge clk_in);
    ctrl_out <= IDLE;
    addr_out <= ~a;
    dq_out <= ~d; // released lines do not keep the last value
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  // read answer fixed at five edges after strobes are seen
  task automatic rd(input psb_pkg::psb_ctrl_type c, input logic [19:0] a, input logic keep,
                    output logic [15:0] d, output logic [1:0] oe, output logic [1:0] wt);
    @(posedge clk_in);
    ctrl_out <= c;
    addr_out <= a;
    repeat (6) @(posedge clk_in);
    #1;
    d = rd_dq_in;
    oe = rd_oe_in;
    wt = {wait_oe_in, wait_in};
    if (!keep) begin
      @(posedge clk_in);
      ctrl_out <= IDLE;
      addr_out <= ~a;
    end
  endtask
  task automatic burst(input logic [19:0] a);
    @(posedge clk_in);
    ctrl_out <= 7'h3C;
    addr_out <= a;
    repeat (2) @(posedge clk_in);
    mem_clk_out <= 1'h1;
    repeat (2) @(posedge clk_in);
    mem_clk_out <= 1'h0;
    ctrl_out <= IDLE;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
endmodule

// >>> dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic ref_clk_in = 1'h0;
  logic reset_n_in = 1'h0;
  psb_pkg::psb_ctrl_type bus_ctrl;
  logic [19:0] addr;
  logic [19:0] baddr;
  logic [15:0] dq_w;
  logic [15:0] dq_r;
  logic [15:0] rcfg;
  logic [15:0] bcfg;
  logic [15:0] d;
  logic [1:0] dq_oe;
  logic [1:0] oe;
  logic [1:0] wt;
  logic mclk;
  logic wait_l;
  logic wait_oe;
  logic ready;
  logic deep_power_down;
  logic burst;
  logic page;
  logic bstart;
  int n_bstart = 0;
  int n_fail = 0;
  int cmp_count = 0;
  always #50 ref_clk_in = ~ref_clk_in;
  // counted mid-cycle, so a pulse held too long counts twice
  always @(negedge ref_clk_in) begin
    if (bstart === 1'h1) n_bstart++;
  end
  psb_async_page_bus #(.ADDR_W(20), .INIT_CYCLES(4)) psb_async_page_bus_i (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .bus_ctrl_in(bus_ctrl), .addr_in(addr),
    .dq_in(dq_w), .mem_clk_in(mclk), .dq_out(dq_r), .dq_oe_out(dq_oe), .wait_out(wait_l),
    .wait_oe_out(wait_oe), .ready_out(ready), .dpd_out(deep_power_down), .burst_mode_out(burst),
    .page_mode_out(page), .burst_start_out(bstart), .burst_addr_out(baddr),
    .refresh_config_out(rcfg), .bus_config_out(bcfg));
  psb_ctrl_model psb_ctrl_model_i (
    .clk_in(ref_clk_in), .rd_dq_in(dq_r), .rd_oe_in(dq_oe), .wait_in(wait_l),
    .wait_oe_in(wait_oe), .ctrl_out(bus_ctrl), .addr_out(addr), .dq_out(dq_w), .mem_clk_out(mclk));
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // read then compare data, lane drive and wait pin
  task automatic rchk(input logic [6:0] c, input logic [19:0] a, input logic [15:0] ed, input logic [1:0] eo,
                      input logic [1:0] ew);
    psb_ctrl_model_i.rd(c, a, 1'h0, d, oe, wt);
    chk("read_data", d & {{8{eo[1]}}, {8{eo[0]}}}, ed);
    chk("lane_oe", oe, eo);
    chk("wait", wt, ew);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_in);
    reset_n_in <= 1'h1;
    #1;
    chk("refresh_default", rcfg, 16'h0010);
    chk("bus_default", bcfg, 16'h8000);
    chk("ready_init", ready, 1'h0);
    chk("async_default", burst, 1'h0);
    for (int i = 0; i < 20 && ready !== 1'h1; i++) @(posedge ref_clk_in);
    if (ready !== 1'h1) begin
      n_fail++;
      print_verdict();
    end
    // full word, then output enable low during a write, then upper lane only
    psb_ctrl_model_i.drive(7'h20, 20'h00010, 16'hA5C3);
    psb_ctrl_model_i.drive(7'h00, 20'h00011, 16'h1234);
    psb_ctrl_model_i.drive(7'h28, 20'h00010, 16'h77EE);
    rchk(7'h10, 20'h00010, 16'h77C3, 2'h3, 2'h2);
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk("wait_released", wait_oe, 1'h0);
    rchk(7'h14, 20'h00011, 16'h0034, 2'h1, 2'h2);
    rchk(7'h18, 20'h00011, 16'h1200, 2'h2, 2'h2);
    rchk(7'h1C, 20'h00011, 16'h0000, 2'h0, 2'h2);
    // selected without strobes, then write strobes while deselected
    psb_ctrl_model_i.drive(7'h3C, 20'h00010, 16'h0000);
    psb_ctrl_model_i.drive(7'h60, 20'h00010, 16'h0000);
    rchk(7'h10, 20'h00010, 16'h77C3, 2'h3, 2'h2);
    chk("nop_cfg", rcfg, 16'h0010);
    // page mode on, writes stay plain
    psb_ctrl_model_i.drive(7'h2D, 20'h00090, 16'h0000);
    chk("page_on", page, 1'h1);
    chk("refresh_cfg", rcfg, 16'h0090);
    psb_ctrl_model_i.drive(7'h20, 20'h00012, 16'hBEEF);
    psb_ctrl_model_i.drive(7'h20, 20'h00022, 16'h5AA5);
    psb_ctrl_model_i.rd(7'h10, 20'h00010, 1'h1, d, oe, wt);
    chk("page_first", d, 16'h77C3);
    psb_ctrl_model_i.rd(7'h10, 20'h00012, 1'h1, d, oe, wt);
    chk("page_hit", d, 16'hBEEF);
    rchk(7'h10, 20'h00022, 16'h5AA5, 2'h3, 2'h2);
    // deep power-down until the refresh register is written again
    psb_ctrl_model_i.drive(7'h2D, 20'h00080, 16'h0000);
    chk("dpd_in", deep_power_down, 1'h1);
    chk("dpd_oe", dq_oe, 2'h0);
    psb_ctrl_model_i.rd(7'h10, 20'h00010, 1'h0, d, oe, wt);
    chk("dpd_read", oe, 2'h0);
    psb_ctrl_model_i.drive(7'h2D, 20'h00010, 16'h0000);
    chk("dpd_out", deep_power_down, 1'h0);
    chk("page_off", page, 1'h0);
    // burst select with wait active high
    psb_ctrl_model_i.drive(7'h2D, 20'h80400, 16'h0000);
    chk("bus_cfg", bcfg, 16'h0400);
    chk("burst_on", burst, 1'h1);
    rchk(7'h10, 20'h00011, 16'h1234, 2'h3, 2'h3);
    psb_ctrl_model_i.burst(20'h0ABCD);
    chk("burst_addr", baddr, 20'h0ABCD);
    chk("burst_start", 20'(n_bstart), 20'h00001);
    print_verdict();
  end
endmodule

// >>> hdl/psb_async_page_bus.sv
`timescale 1ns/100ps
`include "psb_params.svh"
// What this block does
// - read: select, output enable, byte enables low, write enable high; data after access
// - write: select, write enable, byte enables low; output enable ignored
// - write data captured at first rising edge of select or write enable, or once both byte enables are high
// - wait output driven while selected; controller ignores it
// - page mode: low four address bits fast, upper change costs full access
// - writes never use the fast page path
// - page reads enabled only by refresh_config_reg bit 7
// - self-initialise 150 us after power-up, loading both register defaults
// - asynchronous mode after power-up until bus_config_reg changes it
// - burst operation only when bus_config_reg bit 15 selects it
// - wait active level from bus_config_reg bit 10
// - byte enables choose low, high or both data bytes
// - deep power-down held until refresh_config_reg is written
// - standby isolates address and data inputs
// - config select makes a write load a configuration register
// - burst address taken on first clock rise after select falls with address valid
// - wait released to high impedance while deselected
module psb_async_page_bus #(
  parameter int ADDR_W = 20,
  parameter int INIT_CYCLES = `PSB_INIT_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire psb_pkg::psb_ctrl_type bus_ctrl_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire logic mem_clk_in,
  output logic [15:0] dq_out,
  output logic [1:0] dq_oe_out,
  output logic wait_out,
  output logic wait_oe_out,
  output logic ready_out,
  output logic dpd_out,
  output logic burst_mode_out,
  output logic page_mode_out,
  output logic burst_start_out,
  output logic [ADDR_W-1:0] burst_addr_out,
  output logic [15:0] refresh_config_out,
  output logic [15:0] bus_config_out
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int PB = `PSB_PAGE_BITS;

  psb_pkg::psb_ctrl_type ctl;
  psb_pkg::psb_state_type state_reg, state_next;
  logic [11:0] init_cnt_reg, init_cnt_next;
  logic [15:0] rcr_reg, rcr_next, bcr_reg, bcr_next;
  logic [ADDR_W-1:0] addr_hold_reg, addr_hold_next, wr_addr_reg, wr_addr_next;
  logic [ADDR_W-1:0] rd_addr_reg, rd_addr_next, burst_addr_reg, burst_addr_next;
  psb_pkg::psb_word_type wr_word_reg, wr_word_next;
  logic wr_act_reg, wr_act_next, wr_cre_reg, wr_cre_next;
  logic rd_act_reg, rd_act_next, fetched_reg, fetched_next;
  logic [2:0] delay_reg, delay_next;
  logic [15:0] buf_reg [0:1];
  logic [15:0] buf_next [0:1];
  logic [1:0] buf_cnt_reg, buf_cnt_next;
  logic buf_wp_reg, buf_wp_next, buf_rp_reg, buf_rp_next;
  logic out_valid_reg, out_valid_next;
  logic [15:0] dq_reg, dq_next;
  logic [1:0] dq_oe_reg, dq_oe_next;
  logic wait_reg, wait_next, wait_oe_reg, wait_oe_next;
  logic ready_reg, ready_next, dpd_reg, dpd_next, bmode_reg, bmode_next;
  logic mclk_prev_reg, cs_prev_reg, armed_reg, armed_next, bstart_reg, bstart_next;
  logic go, lanes_on, in_dpd, wr_act, rd_act, commit, cfg_wr, rcr_wr, bcr_wr, arr_wr;
  logic page_en, page_hit, new_acc, push, pop, flush, burst_mode, arm, capture;
  logic [ADDR_W-1:0] eff_addr;
  logic [15:0] rd_word;

  assign ctl = bus_ctrl_in;
  // nothing is sampled while deselected or initialising
  assign go = !ctl.cs_n && state_reg != psb_pkg::PSB_INIT;
  assign lanes_on = !ctl.lb_n || !ctl.ub_n;
  assign in_dpd = state_reg == psb_pkg::PSB_DPD;
  assign wr_act = go && !ctl.we_n && (ctl.config_register_select || lanes_on);
  assign rd_act = go && !in_dpd && ctl.we_n && !ctl.oe_n && !ctl.config_register_select && lanes_on;
  assign commit = wr_act_reg && !wr_act;
  assign cfg_wr = commit && wr_cre_reg;
  assign rcr_wr = cfg_wr && wr_addr_reg[`PSB_REG_SEL_MSB:`PSB_REG_SEL_LSB] == `PSB_SEL_RCR;
  assign bcr_wr = cfg_wr && wr_addr_reg[`PSB_REG_SEL_MSB:`PSB_REG_SEL_LSB] == `PSB_SEL_BCR;
  assign arr_wr = commit && !wr_cre_reg && !in_dpd;
  // held low address valid is transparent, a pulse latches on its rise
  assign eff_addr = ctl.adv_n ? addr_hold_reg : addr_in;
  assign page_en = rcr_reg[`PSB_RCR_PAGE_BIT];
  // only back-to-back reads qualify, so writes always pay the full delay
  assign page_hit = rd_act_reg && page_en && eff_addr[ADDR_W-1:PB] == rd_addr_reg[ADDR_W-1:PB];
  assign new_acc = rd_act && (!rd_act_reg || eff_addr != rd_addr_reg);
  assign push = rd_act && !new_acc && delay_reg == 3'h0 && !fetched_reg && buf_cnt_reg != `PSB_BUF_DEPTH;
  assign pop = buf_cnt_reg != 2'h0 && rd_act && !new_acc && !out_valid_reg;
  assign flush = !rd_act || new_acc;
  assign burst_mode = bcr_reg[`PSB_BCR_MODE_BIT] == `PSB_BCR_BURST;
  assign arm = armed_reg || (cs_prev_reg && !ctl.cs_n);
  assign capture = burst_mode && arm && go && mem_clk_in && !mclk_prev_reg && !ctl.adv_n;

  for (genvar g = 0; g < 2; g++) begin : lane
    logic [7:0] lane_mem [0:DEPTH-1];
    always_ff @(posedge ref_clk_in) begin
      if (arr_wr && !wr_word_reg.lanes_n[g]) begin
        lane_mem[wr_addr_reg] <= wr_word_reg.data[g*8 +: 8];
      end
    end
    assign rd_word[g*8 +: 8] = lane_mem[eff_addr];
  end

  always_comb begin
    state_next = state_reg;
    init_cnt_next = init_cnt_reg;
    rcr_next = rcr_reg;
    bcr_next = bcr_reg;
    unique case (state_reg)
      psb_pkg::PSB_INIT: begin
        if (init_cnt_reg == 12'(INIT_CYCLES - 1)) begin
          state_next = psb_pkg::PSB_STANDBY;
        end else begin
          init_cnt_next = init_cnt_reg + 12'h001;
        end
      end
      psb_pkg::PSB_STANDBY: begin
        if (!ctl.cs_n) begin
          state_next = psb_pkg::PSB_ACTIVE;
        end else if (rcr_reg[`PSB_RCR_DPD_BIT] == `PSB_RCR_DPD_ON) begin
          state_next = psb_pkg::PSB_DPD;
        end
      end
      psb_pkg::PSB_ACTIVE: begin
        if (ctl.cs_n) begin
          state_next = psb_pkg::PSB_STANDBY;
        end
      end
      psb_pkg::PSB_DPD: begin
        if (rcr_wr) begin
          state_next = psb_pkg::PSB_STANDBY;
        end
      end
    endcase
    // config value rides on the low address bits
    if (rcr_wr) begin
      rcr_next = wr_addr_reg[`PSB_CFG_MSB:0];
    end
    if (bcr_wr) begin
      bcr_next = wr_addr_reg[`PSB_CFG_MSB:0];
    end
    ready_next = state_next != psb_pkg::PSB_INIT;
    dpd_next = state_next == psb_pkg::PSB_DPD;
    bmode_next = bcr_next[`PSB_BCR_MODE_BIT] == `PSB_BCR_BURST;
  end

  always_comb begin
    addr_hold_next = addr_hold_reg;
    if (go && !ctl.adv_n) begin
      addr_hold_next = addr_in;
    end
    wr_act_next = wr_act;
    wr_word_next = wr_word_reg;
    wr_addr_next = wr_addr_reg;
    wr_cre_next = wr_cre_reg;
    // keep refreshing the sample so the last one before the rise is kept
    if (wr_act) begin
      wr_word_next.lanes_n = {ctl.ub_n, ctl.lb_n};
      wr_word_next.data = dq_in;
      wr_addr_next = eff_addr;
      wr_cre_next = ctl.config_register_select;
    end
  end

  always_comb begin
    rd_act_next = rd_act;
    rd_addr_next = rd_addr_reg;
    delay_next = delay_reg;
    fetched_next = fetched_reg;
    buf_next = buf_reg;
    buf_cnt_next = buf_cnt_reg;
    buf_wp_next = buf_wp_reg;
    buf_rp_next = buf_rp_reg;
    if (new_acc) begin
      rd_addr_next = eff_addr;
      fetched_next = 1'b0;
      delay_next = page_hit ? 3'(`PSB_PAGE_CYCLES - 1) : 3'(`PSB_AA_CYCLES - 1);
    end else if (delay_reg != 3'h0) begin
      delay_next = delay_reg - 3'h1;
    end else if (push) begin
      fetched_next = 1'b1;
    end
    if (flush) begin
      buf_cnt_next = 2'h0;
      buf_wp_next = 1'b0;
      buf_rp_next = 1'b0;
    end else begin
      if (push) begin
        buf_next[buf_wp_reg] = rd_word;
        buf_wp_next = !buf_wp_reg;
      end
      if (pop) begin
        buf_rp_next = !buf_rp_reg;
      end
      buf_cnt_next = buf_cnt_reg + 2'(push) - 2'(pop);
    end
    out_valid_next = !flush && (pop || out_valid_reg);
    dq_next = pop ? buf_reg[buf_rp_reg] : dq_reg;
    dq_oe_next = {2{rd_act && out_valid_next}} & ~{ctl.ub_n, ctl.lb_n};
  end

  always_comb begin
    // wait stays asserted in these modes; controller disregards it
    wait_oe_next = !ctl.cs_n;
    wait_next = bcr_reg[`PSB_BCR_WAIT_POL_BIT];
    armed_next = !ctl.cs_n && arm && !capture;
    bstart_next = capture;
    burst_addr_next = capture ? addr_in : burst_addr_reg;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= psb_pkg::PSB_INIT;
      init_cnt_reg <= 12'h000;
      rcr_reg <= `PSB_RCR_DEFAULT;
      bcr_reg <= `PSB_BCR_DEFAULT;
      ready_reg <= 1'b0;
      dpd_reg <= 1'b0;
      bmode_reg <= 1'b0;
      addr_hold_reg <= '0;
      wr_act_reg <= 1'b0;
      wr_word_reg <= '0;
      wr_addr_reg <= '0;
      wr_cre_reg <= 1'b0;
      rd_act_reg <= 1'b0;
      rd_addr_reg <= '0;
      delay_reg <= 3'h0;
      fetched_reg <= 1'b0;
      buf_reg[0] <= 16'h0000;
      buf_reg[1] <= 16'h0000;
      buf_cnt_reg <= 2'h0;
      buf_wp_reg <= 1'b0;
      buf_rp_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      dq_reg <= 16'h0000;
      dq_oe_reg <= 2'h0;
      wait_reg <= 1'b0;
      wait_oe_reg <= 1'b0;
      mclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
      armed_reg <= 1'b0;
      bstart_reg <= 1'b0;
      burst_addr_reg <= '0;
    end else begin
      state_reg <= state_next;
      init_cnt_reg <= init_cnt_next;
      rcr_reg <= rcr_next;
      bcr_reg <= bcr_next;
      ready_reg <= ready_next;
      dpd_reg <= dpd_next;
      bmode_reg <= bmode_next;
      addr_hold_reg <= addr_hold_next;
      wr_act_reg <= wr_act_next;
      wr_word_reg <= wr_word_next;
      wr_addr_reg <= wr_addr_next;
      wr_cre_reg <= wr_cre_next;
      rd_act_reg <= rd_act_next;
      rd_addr_reg <= rd_addr_next;
      delay_reg <= delay_next;
      fetched_reg <= fetched_next;
      buf_reg <= buf_next;
      buf_cnt_reg <= buf_cnt_next;
      buf_wp_reg <= buf_wp_next;
      buf_rp_reg <= buf_rp_next;
      out_valid_reg <= out_valid_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
      wait_reg <= wait_next;
      wait_oe_reg <= wait_oe_next;
      mclk_prev_reg <= mem_clk_in;
      cs_prev_reg <= ctl.cs_n;
      armed_reg <= armed_next;
      bstart_reg <= bstart_next;
      burst_addr_reg <= burst_addr_next;
    end
  end

  assign dq_out = dq_reg;
  assign dq_oe_out = dq_oe_reg;
  assign wait_out = wait_reg;
  assign wait_oe_out = wait_oe_reg;
  assign ready_out = ready_reg;
  assign dpd_out = dpd_reg;
  assign burst_mode_out = bmode_reg;
  assign page_mode_out = rcr_reg[`PSB_RCR_PAGE_BIT];
  assign burst_start_out = bstart_reg;
  assign burst_addr_out = burst_addr_reg;
  assign refresh_config_out = rcr_reg;
  assign bus_config_out = bcr_reg;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  init_length_a: assert property ($rose(ready_out) |-> init_cnt_reg == 12'(INIT_CYCLES - 1))
    else $error("ready before init time");
  read_drive_a: assert property (rd_act && !new_acc && out_valid_reg |=> dq_oe_out != 2'h0)
    else $error("read not driving data");
  write_quiet_a: assert property (wr_act |=> dq_oe_out == 2'h0)
    else $error("data driven during write");
  write_commit_a: assert property (arr_wr && !wr_word_reg.lanes_n[0] |=>
    lane[0].lane_mem[$past(wr_addr_reg)] == $past(wr_word_reg.data[7:0]))
    else $error("write data not stored at strobe rise");
  lane_select_a: assert property (dq_oe_out[1] |-> $past(!ctl.ub_n) && $past(rd_act))
    else $error("high lane driven without its enable");
  page_delay_a: assert property (new_acc && page_hit |=> delay_reg == 3'(`PSB_PAGE_CYCLES - 1))
    else $error("page hit took wrong delay");
  cfg_load_a: assert property (rcr_wr |=> refresh_config_out == $past(wr_addr_reg[`PSB_CFG_MSB:0]))
    else $error("config write not loaded");
  dpd_hold_a: assert property (dpd_out && !rcr_wr |=> dpd_out)
    else $error("left power-down without config write");
  wait_release_a: assert property (ctl.cs_n |=> !wait_oe_out)
    else $error("wait driven while deselected");
  wait_level_a: assert property (wait_oe_out |-> wait_out == $past(bcr_reg[`PSB_BCR_WAIT_POL_BIT]))
    else $error("wait level not from config");
  standby_iso_a: assert property (ctl.cs_n |=> $stable(addr_hold_reg) && $stable(wr_word_reg))
    else $error("inputs sampled in standby");
  burst_gate_a: assert property (burst_start_out |-> $past(burst_mode) && $past(!ctl.adv_n))
    else $error("burst start outside burst mode");
  noop_stable_a: assert property (go && !wr_act && !rd_act && !commit |=>
    $stable(rcr_reg) && $stable(bcr_reg))
    else $error("idle cycle changed config");

  read_cover_c: cover property (new_acc ##[1:4] (dq_oe_out == 2'h3));
  page_cover_c: cover property (new_acc && page_hit);
  write_cover_c: cover property (arr_wr);
  dpd_cover_c: cover property ($fell(dpd_out));
endmodule

// >>> hdl/psb_params.svh
`ifndef PSB_PARAMS_SVH
`define PSB_PARAMS_SVH
`define PSB_CLK_PERIOD_NS 100
`define PSB_CLK_MHZ 10
`define PSB_INIT_TIME_US 150
`define PSB_INIT_CYCLES (`PSB_INIT_TIME_US * `PSB_CLK_MHZ)
`define PSB_T_AA_NS 70
`define PSB_T_PAGE_NS 20
`define PSB_AA_CYCLES ((`PSB_T_AA_NS + `PSB_CLK_PERIOD_NS - 1) / `PSB_CLK_PERIOD_NS)
`define PSB_PAGE_CYCLES ((`PSB_T_PAGE_NS + `PSB_CLK_PERIOD_NS - 1) / `PSB_CLK_PERIOD_NS)
`define PSB_PAGE_BITS 4
`define PSB_RCR_PAGE_BIT 7
`define PSB_RCR_DPD_BIT 4
`define PSB_RCR_DPD_ON 1'h0
`define PSB_BCR_MODE_BIT 15
`define PSB_BCR_BURST 1'h0
`define PSB_BCR_WAIT_POL_BIT 10
`define PSB_REG_SEL_MSB 19
`define PSB_REG_SEL_LSB 18
`define PSB_SEL_RCR 2'h0
`define PSB_SEL_BCR 2'h2
`define PSB_CFG_MSB 15
`define PSB_RCR_DEFAULT 16'h0010
`define PSB_BCR_DEFAULT 16'h8000
`define PSB_BUF_DEPTH 2'h2
`endif

// >>> hdl/psb_pkg.sv
package psb_pkg;
  typedef enum logic [1:0] {PSB_INIT, PSB_STANDBY, PSB_ACTIVE, PSB_DPD} psb_state_type;
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic lb_n;
    logic ub_n;
    logic adv_n;
    logic config_register_select;
  } psb_ctrl_type;
  typedef struct packed {
    logic [1:0] lanes_n;
    logic [15:0] data;
  } psb_word_type;
endpackage
